// *** hw/rig_pkg.sv ***
/*
  constants shared by the reset and interrupt generator: register map,
  field positions, reset values, sequence lengths and state types.
  assumes nothing of its surroundings.
*/
package rig_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h08;
  localparam logic [7:0] ADDR_SERVICE  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  // config field positions
  localparam int CFG_CME     = 0;
  localparam int CFG_SELF_CLOCK_MODE_ENABLE    = 1;
  localparam int CFG_WINDOW  = 2;
  localparam int CFG_PSEUDO_STOP_SELECT_RUN = 3;
  localparam int CFG_WRATE_LO = 4;
  localparam int CFG_RTI_LO  = 8;
  localparam logic [11:0] CFG_RESET = 12'h0003;
  // irq enable / flag bit positions
  localparam int IRQ_PERIODIC = 0;
  localparam int IRQ_LOCK     = 1;
  localparam int IRQ_SELFCLK  = 2;
  // watchdog service words
  localparam logic [7:0] SVC_ARM  = 8'h55;
  localparam logic [7:0] SVC_FIRE = 8'hAA;
  // reset sequence lengths in system clock cycles
  localparam int DRIVE_BASE = 128;
  localparam int SYNC_N     = 3;
  localparam logic [7:0] DRIVE_LAST  = 8'(DRIVE_BASE + SYNC_N - 1);
  localparam logic [7:0] SETTLE_LAST = 8'(64 - 1);
  // synchroniser inputs
  localparam int SYNC_W = 5;
  typedef enum logic [2:0] {S_CLKWAIT, S_DRIVE, S_SETTLE, S_HOLD, S_RUN} seq_state_t;
  typedef enum logic [1:0] {VEC_NORMAL, VEC_CLKMON, VEC_WDOG} vector_t;
endpackage

// *** hw/sync_if.sv ***
/*
  carrier between the generator and its input synchroniser.
  assumes one clock, the generator's own.
*/
`timescale 1ns/100ps
interface sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  logic [W-1:0] changed;
  modport sync_side (input raw, output stable, output changed);
  modport user_side (output raw, input stable, input changed);
endinterface

// *** hw/input_sync.sv ***
/*
  three-stage synchroniser with agreement filter for asynchronous pins.
  assumes inputs may change at any time relative to mclk_in.
*/
`timescale 1ns/100ps
module input_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // pins in, filtered levels out
  sync_if.sync_side port
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;
  logic [W-1:0] stable_reg, stable_next;
  logic [W-1:0] chg_reg, chg_next;

  // a bit takes its new value only once stages two and three agree
  always_comb begin
    stable_next = stable_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
      end
    end
    chg_next = stable_next ^ stable_reg;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg     <= RST_VAL;
      s2_reg     <= RST_VAL;
      s3_reg     <= RST_VAL;
      stable_reg <= RST_VAL;
      chg_reg    <= '0;
    end else begin
      s1_reg     <= port.raw;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
      chg_reg    <= chg_next;
    end
  end

  assign port.stable  = stable_reg;
  assign port.changed = chg_reg;
endmodule

// *** hw/reset_and_interrupt_generator.sv ***
/*
  reset sequencer, watchdog and interrupt flags of the clock and reset unit.
  assumes rst_in is the power-on detector output; pins are asynchronous and
  are synchronised here; the reset pin has an external pull-up.
*/
`timescale 1ns/100ps
module reset_and_interrupt_generator
  import rig_pkg::*;
#(
  parameter int WDOG_BASE_LOG2 = 10,
  parameter int RTI_BASE_LOG2  = 10
) (
  // clock and power-on reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rd_data_out,
  // bidirectional reset pin, low active
  input  wire logic        reset_pin_n_in,
  output logic             reset_pin_n_out,
  output logic             reset_pin_oe_out,
  // clock monitor, quality checker, pll, stop mode
  input  wire logic        clock_loss_in,
  input  wire logic        clock_ok_in,
  input  wire logic        clock_check_fail_in,
  input  wire logic        pll_lock_in,
  input  wire logic        pseudo_stop_in,
  // reset results
  output logic             sys_reset_out,
  output logic      [1:0]  vector_sel_out,
  output logic             self_clock_mode_out,
  // interrupt requests
  output logic             periodic_irq_out,
  output logic             pll_lock_irq_out,
  output logic             self_clock_irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronised inputs: pin low, loss, ok, fail, lock
  sync_if #(.W(SYNC_W)) sif ();
  logic pin_low, loss_s, ok_s, fail_s, pstop_s;
  logic lock_chg;

  assign sif.raw = {pll_lock_in, clock_check_fail_in, clock_ok_in, clock_loss_in,
                    ~reset_pin_n_in};

  input_sync #(.W(SYNC_W), .RST_VAL(5'h01)) u_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .port    (sif.sync_side)
  );

  assign pin_low  = sif.stable[0];
  assign loss_s   = sif.stable[1];
  assign ok_s     = sif.stable[2];
  assign fail_s   = sif.stable[3];
  assign lock_chg = sif.changed[4];

  // pseudo-stop comes from on-chip logic on this clock
  assign pstop_s = pseudo_stop_in;

  ////////////////////////////////////////////////////////////////////////////
  // registers and sequencer state
  seq_state_t  state_reg, state_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [11:0] cfg_reg, cfg_next;
  logic [2:0]  en_reg, en_next;
  logic [2:0]  flag_reg, flag_next;
  logic        scm_reg, scm_next;
  logic        cmf_reg, cmf_next;
  logic        wdf_reg, wdf_next;
  vector_t     vec_reg, vec_next;
  logic        armed_reg, armed_next;
  logic [23:0] wd_cnt_reg, wd_cnt_next;
  logic [23:0] rti_cnt_reg, rti_cnt_next;
  logic [31:0] rd_reg, rd_next;

  logic        clock_monitor_enable, self_clock_mode_enable, win_en, pseudo_stop_select_run;
  logic [2:0]  wrate;
  logic [3:0]  rti_sel;
  logic        svc_wr, svc_ok, svc_bad, svc_early;
  logic        cm_evt, wd_timeout, wd_evt, rti_tick, scm_chg;
  logic [23:0] wd_period, rti_period;

  assign clock_monitor_enable      = cfg_reg[CFG_CME];
  assign self_clock_mode_enable     = cfg_reg[CFG_SELF_CLOCK_MODE_ENABLE];
  assign win_en   = cfg_reg[CFG_WINDOW];
  assign pseudo_stop_select_run = cfg_reg[CFG_PSEUDO_STOP_SELECT_RUN];
  assign wrate    = cfg_reg[CFG_WRATE_LO +: 3];
  assign rti_sel  = cfg_reg[CFG_RTI_LO +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  assign cm_evt = clock_monitor_enable & loss_s & ~self_clock_mode_enable;

  assign wd_period  = 24'(1) << (WDOG_BASE_LOG2 + 24'(wrate));
  assign rti_period = 24'(1) << (RTI_BASE_LOG2 + 24'(rti_sel));

  assign svc_wr    = wr_in && (addr_in == ADDR_SERVICE) && (state_reg == S_RUN);
  assign svc_ok    = (wr_data_in[7:0] == SVC_ARM) || (wr_data_in[7:0] == SVC_FIRE);
  assign svc_bad   = svc_wr && (wrate != 3'h0) && !svc_ok;
  // window opens at three quarters of the period
  assign svc_early = svc_wr && (wrate != 3'h0) && svc_ok && win_en &&
                     (wd_cnt_reg < (wd_period - (wd_period >> 2)));
  assign wd_timeout = (state_reg == S_RUN) && (wrate != 3'h0) &&
                      (wd_cnt_reg == wd_period - 24'(1));
  assign wd_evt = wd_timeout | svc_bad | svc_early;

  assign rti_tick = (rti_sel != 4'h0) && (state_reg == S_RUN) &&
                    (!pstop_s || pseudo_stop_select_run) &&
                    (rti_cnt_reg == rti_period - 24'(1));

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 8'h01;
    cmf_next   = cmf_reg | cm_evt;
    wdf_next   = wdf_reg | wd_evt;
    vec_next   = vec_reg;
    case (state_reg)
      S_CLKWAIT: begin
        cnt_next = 8'h00;
        if (ok_s || fail_s) begin
          state_next = S_DRIVE;
        end
      end
      S_DRIVE: begin
        if (cnt_reg == DRIVE_LAST) begin
          state_next = S_SETTLE;
          cnt_next   = 8'h00;
        end
      end
      S_SETTLE: begin
        if (cnt_reg == SETTLE_LAST) begin
          cnt_next = 8'h00;
          if (cmf_reg) begin
            vec_next = VEC_CLKMON;
          end else if (wdf_reg) begin
            vec_next = VEC_WDOG;
          end else begin
            vec_next = VEC_NORMAL;
          end
          cmf_next   = 1'b0;
          wdf_next   = 1'b0;
          state_next = pin_low ? S_HOLD : S_RUN;
        end
      end
      S_HOLD: begin
        cnt_next = 8'h00;
        if (!pin_low) begin
          state_next = S_RUN;
        end
      end
      S_RUN: begin
        cnt_next = 8'h00;
        if (pin_low || wd_evt) begin
          state_next = S_DRIVE;
        end
      end
      default: begin
        state_next = S_CLKWAIT;
      end
    endcase
    // a clock monitor event restarts the sequence from any state but S_CLKWAIT
    if (cm_evt && state_reg != S_CLKWAIT) begin
      state_next = S_DRIVE;
      cnt_next   = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, self-clock mode, flags, watchdog, timer, bus
  always_comb begin
    cfg_next     = cfg_reg;
    en_next      = en_reg;
    flag_next    = flag_reg;
    scm_next     = scm_reg;
    armed_next   = armed_reg;
    wd_cnt_next  = wd_cnt_reg + 24'(1);
    rti_cnt_next = rti_cnt_reg;
    rd_next      = 32'h0000_0000;
    if (wr_in && addr_in == ADDR_CONFIG) begin
      cfg_next = wr_data_in[11:0];
    end
    if (wr_in && addr_in == ADDR_IRQ_EN) begin
      en_next = wr_data_in[2:0];
    end
    if (wr_in && addr_in == ADDR_IRQ_FLAG) begin
      flag_next = flag_reg & ~wr_data_in[2:0];
    end
    // self-clock mode: enter on failed check or clock loss, leave on good clock
    if (self_clock_mode_enable) begin
      if (!scm_reg && ((state_reg == S_CLKWAIT && fail_s) || (clock_monitor_enable && loss_s))) begin
        scm_next = 1'b1;
      end else if (scm_reg && ok_s) begin
        scm_next = 1'b0;
      end
    end
    if (cm_evt) begin
      cfg_next = CFG_RESET;
      scm_next = 1'b1;
    end
    // watchdog restarts on the service pair, and is held outside run
    if (svc_wr && !wd_evt) begin
      if (wr_data_in[7:0] == SVC_ARM) begin
        armed_next = 1'b1;
      end else if (armed_reg) begin
        armed_next  = 1'b0;
        wd_cnt_next = 24'(0);
      end
    end
    if (state_reg != S_RUN || wrate == 3'h0 || wd_evt) begin
      wd_cnt_next = 24'(0);
      armed_next  = 1'b0;
    end
    if (rti_sel == 4'h0 || state_reg != S_RUN || rti_tick) begin
      rti_cnt_next = 24'(0);
    end else if (!pstop_s || pseudo_stop_select_run) begin
      rti_cnt_next = rti_cnt_reg + 24'(1);
    end
    // hardware sets win over a simultaneous software clear
    if (rti_tick) begin
      flag_next[IRQ_PERIODIC] = 1'b1;
    end
    if (lock_chg) begin
      flag_next[IRQ_LOCK] = 1'b1;
    end
    if (scm_chg) begin
      flag_next[IRQ_SELFCLK] = 1'b1;
    end
    if (rd_in) begin
      case (addr_in)
        ADDR_CONFIG:   rd_next = {20'h0_0000, cfg_reg};
        ADDR_IRQ_EN:   rd_next = {29'h0000_0000, en_reg};
        ADDR_IRQ_FLAG: rd_next = {29'h0000_0000, flag_reg};
        ADDR_STATUS:   rd_next = {27'h000_0000, vec_reg, sif.stable[4], armed_reg,
                                  scm_reg};
        default:       rd_next = 32'h0000_0000;
      endcase
    end
  end

  // flagged from the registered state so the flag follows the mode change
  logic scm_prev_reg;
  assign scm_chg = scm_reg ^ scm_prev_reg;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg    <= S_CLKWAIT;
      cnt_reg      <= 8'h00;
      cfg_reg      <= CFG_RESET;
      en_reg       <= 3'h0;
      flag_reg     <= 3'h0;
      scm_reg      <= 1'b0;
      scm_prev_reg <= 1'b0;
      cmf_reg      <= 1'b0;
      wdf_reg      <= 1'b0;
      vec_reg      <= VEC_NORMAL;
      armed_reg    <= 1'b0;
      wd_cnt_reg   <= 24'h00_0000;
      rti_cnt_reg  <= 24'h00_0000;
      rd_reg       <= 32'h0000_0000;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      cfg_reg      <= cfg_next;
      en_reg       <= en_next;
      flag_reg     <= flag_next;
      scm_reg      <= scm_next;
      scm_prev_reg <= scm_reg;
      cmf_reg      <= cmf_next;
      wdf_reg      <= wdf_next;
      vec_reg      <= vec_next;
      armed_reg    <= armed_next;
      wd_cnt_reg   <= wd_cnt_next;
      rti_cnt_reg  <= rti_cnt_next;
      rd_reg       <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd_data_out         = rd_reg;
  assign reset_pin_n_out     = 1'b0;
  assign reset_pin_oe_out    = (state_reg == S_CLKWAIT) || (state_reg == S_DRIVE);
  assign sys_reset_out       = (state_reg != S_RUN);
  assign vector_sel_out      = vec_reg;
  assign self_clock_mode_out = scm_reg;
  assign periodic_irq_out    = flag_reg[IRQ_PERIODIC] & en_reg[IRQ_PERIODIC];
  assign pll_lock_irq_out    = flag_reg[IRQ_LOCK] & en_reg[IRQ_LOCK];
  assign self_clock_irq_out  = flag_reg[IRQ_SELFCLK] & en_reg[IRQ_SELFCLK];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence seq_settle_done;
    state_reg == S_SETTLE && cnt_reg == SETTLE_LAST;
  endsequence
  sequence seq_bad_service;
    svc_bad && !cm_evt;
  endsequence

  chk_pin_release: assert property ($fell(reset_pin_oe_out) && $past(state_reg) == S_DRIVE |-> $past(cnt_reg) == 8'd130) else $error("pin released early");
  chk_settle_len: assert property (seq_settle_done |-> $past(state_reg, 64) == S_DRIVE && $past(state_reg, 63) == S_SETTLE) else $error("settle length wrong");
  chk_hold_ext: assert property (state_reg == S_HOLD && pin_low |=> sys_reset_out) else $error("reset dropped while pin low");
  chk_vec_clkmon: assert property (seq_settle_done ##0 cmf_reg && !cm_evt |=> vector_sel_out == VEC_CLKMON) else $error("clock monitor vector missed");
  chk_vec_wdog: assert property (seq_settle_done ##0 !cmf_reg && wdf_reg && !cm_evt |=> vector_sel_out == VEC_WDOG) else $error("watchdog vector missed");
  chk_vec_normal: assert property (seq_settle_done ##0 !cmf_reg && !wdf_reg && !cm_evt && !wd_evt |=> vector_sel_out == VEC_NORMAL) else $error("normal vector missed");
  chk_cm_defaults: assert property (cm_evt |=> clock_monitor_enable && self_clock_mode_enable && self_clock_mode_out && state_reg == S_DRIVE) else $error("clock monitor reset incomplete");
  chk_bad_service: assert property (seq_bad_service |=> state_reg == S_DRIVE ##1 reset_pin_oe_out) else $error("bad service word ignored");
  chk_clkwait_exit: assert property ($past(state_reg) == S_CLKWAIT && state_reg == S_DRIVE |-> $past(ok_s || fail_s)) else $error("sequence started before clock check");
  chk_periodic_flag: assert property (rti_tick |=> flag_reg[IRQ_PERIODIC]) else $error("periodic flag lost");
  chk_lock_flag: assert property (lock_chg |=> flag_reg[IRQ_LOCK]) else $error("lock flag lost");
  chk_scm_flag: assert property (scm_chg |=> flag_reg[IRQ_SELFCLK]) else $error("self-clock flag lost");
  chk_scm_enable: assert property ($changed(scm_reg) |-> $past(self_clock_mode_enable) || $past(cm_evt)) else $error("self-clock changed while disabled");
  chk_wdog_off: assert property (wrate == 3'h0 && state_reg == S_RUN |=> wd_cnt_reg == 24'h00_0000) else $error("watchdog active at rate zero");
endmodule

// *** bench/reset_pin_model.sv ***
/*
  board around the low-active reset pin: a pull-up, plus an outside
  source that the bench can order to hold the pin low.
  assumes the device only ever pulls the pin low, never drives it high.
*/
`timescale 1ns/100ps
module reset_pin_model (
  // device side of the pin
  input  wire logic dev_pin_n_in,
  input  wire logic dev_oe_in,
  // bench control
  input  wire logic hold_low_in,
  // resolved pin level
  output logic      pin_n_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // released pin floats up to the pull-up level, never keeps a stale low
  assign pin_n_out = ((dev_oe_in && !dev_pin_n_in) || hold_low_in) ? 1'b0 : 1'b1;
endmodule

// *** bench/tb_top.sv ***
/*
  self-checking bench of the reset and interrupt generator.
  assumes the register map and sequence lengths of rig_pkg and a pulled-up reset pin.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_top;
  import rig_pkg::*;
  logic        mclk_in    = 1'b0;
  logic        rst_in     = 1'b1;
  logic [7:0]  addr_in    = 8'h00;
  logic [31:0] wr_data_in = 32'h0000_0000;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic        hold_low   = 1'b0;
  logic        clock_loss = 1'b0;
  logic        clock_ok   = 1'b0;
  logic        pll_lock   = 1'b0;
  logic        pstop      = 1'b0;
  logic        rd_q       = 1'b0;
  logic [31:0] lfsr       = 32'hfec5_de9d;
  logic [31:0] rd_data_out, got_e, got_m;
  logic        pin_n, pin_n_drv, pin_oe, sys_reset, self_clock_mode, irq_per, irq_lock, irq_scm;
  logic [1:0]  vec;
  logic [2:0]  irqs;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          error_cnt  = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          drv, stl;

  initial forever #12.5 mclk_in = ~mclk_in;

  assign irqs = {irq_scm, irq_lock, irq_per};

  reset_and_interrupt_generator #(.WDOG_BASE_LOG2(2), .RTI_BASE_LOG2(2))
  u_reset_and_interrupt_generator (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .reset_pin_n_in(pin_n), .reset_pin_n_out(pin_n_drv), .reset_pin_oe_out(pin_oe),
    .clock_loss_in(clock_loss), .clock_ok_in(clock_ok), .clock_check_fail_in(1'b0),
    .pll_lock_in(pll_lock), .pseudo_stop_in(pstop), .sys_reset_out(sys_reset),
    .vector_sel_out(vec), .self_clock_mode_out(self_clock_mode), .periodic_irq_out(irq_per),
    .pll_lock_irq_out(irq_lock), .self_clock_irq_out(irq_scm));

  reset_pin_model u_reset_pin_model (
    .dev_pin_n_in(pin_n_drv), .dev_oe_in(pin_oe), .hold_low_in(hold_low), .pin_n_out(pin_n));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // the expectation is noted before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask

  // counts pin drive cycles, then the remaining internal reset cycles
  task automatic seq(output int d, output int s);
    d = 0;
    s = 0;
    while (pin_oe !== 1'b1 && s < 100) begin
      @(negedge mclk_in);
      s++;
    end
    s = 0;
    while (pin_oe === 1'b1 && d < 400) begin
      d++;
      @(negedge mclk_in);
    end
    while (sys_reset === 1'b1 && s < 1000) begin
      s++;
      @(negedge mclk_in);
    end
  endtask

  task automatic wait_irq(input int k);
    int i;
    i = 0;
    while (irqs[k] !== 1'b1 && i < 40) begin
      @(negedge mclk_in);
      i++;
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // read answers stand only in the cycle after the strobe
  always @(posedge mclk_in) rd_q <= rd_in;
  always @(negedge mclk_in) begin
    if (rd_q && exp_q.size() > 0) begin
      got_e = exp_q.pop_front();
      got_m = msk_q.pop_front();
      `CHK(rd_data_out & got_m, got_e & got_m)
    end
  end

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH t=%0t run did not finish", $time);
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] b;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (10) @(negedge mclk_in);
    `CHK(sys_reset, 1'b1)
    `CHK(pin_oe, 1'b1)
    clock_ok <= 1'b1;
    seq(drv, stl);
    `CHK(stl, 64)
    `CHK(sys_reset, 1'b0)
    rd(ADDR_CONFIG, {20'h0_0000, CFG_RESET}, 32'h0000_0fff);
    rd(ADDR_IRQ_EN, 32'h0000_0000, 32'h0000_0007);
    rd(8'h20, 32'h0000_0000, 32'hffff_ffff);
    `CHK(vec, VEC_NORMAL)
    repeat (100) @(negedge mclk_in);
    `CHK(sys_reset, 1'b0)
    $display("test done: power-on");

    @(posedge mclk_in);
    hold_low <= 1'b1;
    fork
      begin
        repeat (300) @(posedge mclk_in);
        hold_low <= 1'b0;
      end
      seq(drv, stl);
    join
    `CHK(drv, DRIVE_BASE + SYNC_N)
    `CHK(stl >= 160 && stl <= 180, 1'b1)
    `CHK(vec, VEC_NORMAL)
    $display("test done: external pin");

    // bad word, then premature word in windowed mode
    for (int i = 0; i < 2; i++) begin
      b = 8'(next_rand());
      if (b == SVC_ARM || b == SVC_FIRE)
        b = 8'h00;
      wr(ADDR_CONFIG, (i == 1) ? 32'h0000_0037 : 32'h0000_0033);
      wr(ADDR_SERVICE, {24'h00_0000, (i == 1) ? SVC_ARM : b});
      seq(drv, stl);
      `CHK(drv, DRIVE_BASE + SYNC_N)
      wr(ADDR_CONFIG, 32'h0000_0003);
      `CHK(vec, VEC_WDOG)
    end
    wr(ADDR_CONFIG, 32'h0000_0033);
    repeat (8) begin
      wr(ADDR_SERVICE, {24'h00_0000, SVC_ARM});
      wr(ADDR_SERVICE, {24'h00_0000, SVC_FIRE});
      repeat (6) @(posedge mclk_in);
    end
    `CHK(sys_reset, 1'b0)
    seq(drv, stl);
    `CHK(drv, DRIVE_BASE + SYNC_N)
    wr(ADDR_CONFIG, 32'h0000_0003);
    `CHK(vec, VEC_WDOG)
    $display("test done: watchdog");

    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CONFIG, (j == 0) ? 32'h0000_0000 : 32'h0000_0003);
      clock_loss <= 1'b1;
      repeat (20) @(negedge mclk_in);
      `CHK(sys_reset, 1'b0)
      clock_loss <= 1'b0;
      repeat (10) @(posedge mclk_in);
    end
    wr(ADDR_IRQ_FLAG, 32'h0000_0007);
    wr(ADDR_CONFIG, 32'h0000_0001);
    clock_ok <= 1'b0;
    clock_loss <= 1'b1;
    wait (pin_oe === 1'b1);
    @(negedge mclk_in);
    `CHK(self_clock_mode, 1'b1)
    @(posedge mclk_in);
    clock_loss <= 1'b0;
    clock_ok <= 1'b1;
    repeat (40) @(negedge mclk_in);
    `CHK(self_clock_mode, 1'b0)
    `CHK(sys_reset, 1'b1)
    seq(drv, stl);
    `CHK(drv, DRIVE_BASE + SYNC_N - 40)
    `CHK(stl, 64)
    rd(ADDR_CONFIG, 32'h0000_0003, 32'h0000_0fff);
    `CHK(vec, VEC_CLKMON)
    rd(ADDR_IRQ_FLAG, 32'h0000_0004, 32'h0000_0004);
    wr(ADDR_IRQ_EN, 32'h0000_0004);
    wait_irq(2);
    `CHK(irq_scm, 1'b1)
    wr(ADDR_IRQ_FLAG, 32'h0000_0004);
    repeat (3) @(negedge mclk_in);
    `CHK(irq_scm, 1'b0)
    $display("test done: clock monitor");

    pstop <= 1'b1;
    wr(ADDR_IRQ_EN, 32'h0000_0002);
    wr(ADDR_CONFIG, 32'h0000_010b);
    repeat (20) @(negedge mclk_in);
    `CHK(irq_per, 1'b0)
    rd(ADDR_IRQ_FLAG, 32'h0000_0001, 32'h0000_0001);
    wr(ADDR_IRQ_EN, 32'h0000_0003);
    wait_irq(0);
    `CHK(irq_per, 1'b1)
    wr(ADDR_CONFIG, 32'h0000_0003);
    wr(ADDR_IRQ_FLAG, 32'h0000_0001);
    repeat (3) @(negedge mclk_in);
    `CHK(irq_per, 1'b0)
    pstop <= 1'b0;
    repeat (2) begin
      @(posedge mclk_in);
      pll_lock <= !pll_lock;
      wait_irq(1);
      `CHK(irq_lock, 1'b1)
      wr(ADDR_IRQ_FLAG, 32'h0000_0002);
      repeat (3) @(negedge mclk_in);
      `CHK(irq_lock, 1'b0)
    end
    $display("test done: interrupts");

    @(posedge mclk_in);
    #5;
    rst_in = 1'b1;
    #1;
    `CHK(sys_reset, 1'b1)
    `CHK(pin_oe, 1'b1)
    $display("test done: asynchronous entry");
    wrap_up();
  end
endmodule
